// ### include/i2ct_pkg.sv
/*
 * i2ct_pkg: register map, field positions, reset values and shared types
 * for the I2C target data/interrupt block.
 * Assumes a 32-bit APB register bus with word-aligned byte addresses.
 */
package i2ct_pkg;

    localparam int APB_AW = 8;
    localparam int APB_DW = 32;

    // register byte offsets
    localparam logic [APB_AW-1:0] OFS_CTRL_STATUS = 8'h04;
    localparam logic [APB_AW-1:0] OFS_DATA_BYTE = 8'h08;
    localparam logic [APB_AW-1:0] OFS_IRQ_MASK = 8'h0C;
    localparam logic [APB_AW-1:0] OFS_IRQ_RAW = 8'h10;
    localparam logic [APB_AW-1:0] OFS_IRQ_MASKED = 8'h14;
    localparam logic [APB_AW-1:0] OFS_IRQ_CLEAR = 8'h18;

    // field positions
    localparam int BIT_RECEIVE_PENDING = 0;
    localparam int BIT_TRANSMIT_PENDING = 1;
    localparam int BIT_TARGET_ENABLE = 0;
    localparam int BIT_DATA_IRQ = 0;
    localparam int DATA_MSB = 7;

    // reset values
    localparam logic [7:0] RST_DATA_BYTE = 8'h00;
    localparam logic RST_IRQ_ENABLE = 1'b0;
    localparam logic RST_TARGET_ENABLE = 1'b0;

    // default own address; value is arbitrary
    localparam logic [6:0] DEF_OWN_ADDR = 7'h3A;
    localparam logic [6:0] MIN_OWN_ADDR = 7'h08;
    localparam logic [6:0] MAX_OWN_ADDR = 7'h77;

    localparam logic [3:0] BITS_PER_BYTE = 4'h8;

    // synchronised bus line levels
    typedef struct packed {
        logic scl;
        logic sda;
    } i2ct_lines_t;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_ADDR_ACK,
        ST_RX,
        ST_RX_ACK,
        ST_TX,
        ST_TX_ACK
    } i2ct_state_t;

endpackage

// ### logic/i2ct_target.sv
/*
 * i2ct_target: I2C target with a shared transfer byte register, a data
 * interrupt with raw/masked status and clock stretching, behind an APB slave.
 * Assumes scl/sda arrive asynchronously and are resolved open-drain outside;
 * oe high pulls the line low.
 */
// Notes on behaviour
// - one data register: source of sent byte, destination of received byte
// - byte in bits 7:0, read/write, resets zero; upper bits read zero
// - one mask bit governs the shared received/requested data interrupt
// - mask one: pending raw data interrupt drives the interrupt output
// - mask zero by reset: interrupt blocked, raw status still recorded
// - while received byte unread, hold scl low until software reads it
// - raw bit set on receive or request; masked equals raw and mask
`timescale 1ns/1ns
module i2ct_target
    import i2ct_pkg::*;
#(
    parameter logic [6:0] OWN_ADDR = DEF_OWN_ADDR
)
(
    input wire logic pclk, // system clock
    input wire logic presetn, // async reset, active low
    input wire logic psel, // apb select
    input wire logic penable, // apb access phase
    input wire logic pwrite, // apb direction
    input wire logic [APB_AW-1:0] paddr, // apb byte address
    input wire logic [APB_DW-1:0] pwdata, // apb write data
    output logic [APB_DW-1:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error on unmapped address
    input wire logic scl_in, // bus clock level
    output logic scl_out, // bus clock drive value
    output logic scl_oe, // pull bus clock low
    input wire logic sda_in, // bus data level
    output logic sda_out, // bus data drive value
    output logic sda_oe, // pull bus data low
    output logic irq // data interrupt, level
);

    if (OWN_ADDR < MIN_OWN_ADDR || OWN_ADDR > MAX_OWN_ADDR)
    begin : g_bad_addr
        $error("own address outside the usable range");
    end

    // apb decode
    logic pready_q;
    wire logic access = psel && penable;
    wire logic fire = access && pready_q;
    wire logic wr_fire = fire && pwrite;
    wire logic rd_fire = fire && !pwrite;
    wire logic sel_ctrl = (paddr == OFS_CTRL_STATUS);
    wire logic sel_data = (paddr == OFS_DATA_BYTE);
    wire logic sel_mask = (paddr == OFS_IRQ_MASK);
    wire logic sel_raw = (paddr == OFS_IRQ_RAW);
    wire logic sel_masked = (paddr == OFS_IRQ_MASKED);
    wire logic sel_clear = (paddr == OFS_IRQ_CLEAR);
    wire logic mapped = sel_ctrl || sel_data || sel_mask || sel_raw
        || sel_masked || sel_clear;

    logic [APB_DW-1:0] prdata_q;
    logic [7:0] data_q;
    logic irq_en_q;
    logic irq_raw_q;
    logic enable_q;
    logic rx_pend_q;
    logic tx_pend_q;
    logic irq_q;
    // line synchronisers
    i2ct_lines_t sync1_q;
    i2ct_lines_t sync2_q;
    i2ct_lines_t prev_q;
    // protocol engine
    i2ct_state_t state_q;
    logic [7:0] shift_q;
    logic [3:0] cnt_q;
    logic rw_q;
    logic ack_ok_q;
    logic scl_oe_q;
    logic sda_oe_q;
    wire logic scl_rise = sync2_q.scl && !prev_q.scl;
    wire logic scl_fall = !sync2_q.scl && prev_q.scl;
    wire logic start_cond = prev_q.scl && sync2_q.scl && prev_q.sda && !sync2_q.sda;
    wire logic stop_cond = prev_q.scl && sync2_q.scl && !prev_q.sda && sync2_q.sda;
    wire logic byte_done = (cnt_q == BITS_PER_BYTE);
    wire logic addr_hit = (shift_q[7:1] == OWN_ADDR);
    // engine events
    wire logic rx_capture = (state_q == ST_RX) && scl_fall && byte_done;
    wire logic tx_request = ((state_q == ST_ADDR_ACK) && scl_fall && rw_q)
        || ((state_q == ST_TX_ACK) && scl_fall && ack_ok_q);
    wire logic data_event = rx_capture || tx_request;
    wire logic tx_load = wr_fire && sel_data && tx_pend_q && (state_q == ST_TX);
    // stretch while a byte waits on software
    wire logic stretch = ((state_q == ST_RX_ACK) && rx_pend_q)
        || ((state_q == ST_TX) && tx_pend_q);
    wire logic irq_masked = irq_raw_q && irq_en_q;
    // read mux; reserved bits stay zero
    logic [APB_DW-1:0] rd_mux;
    always_comb
    begin
        rd_mux = '0;
        if (sel_data)
            rd_mux[DATA_MSB:0] = data_q;
        rd_mux[BIT_RECEIVE_PENDING] |= sel_ctrl && rx_pend_q;
        rd_mux[BIT_TRANSMIT_PENDING] |= sel_ctrl && tx_pend_q;
        rd_mux[BIT_DATA_IRQ] |= (sel_mask && irq_en_q) || (sel_raw && irq_raw_q)
            || (sel_masked && irq_masked);
    end

    assign pready = pready_q;
    assign prdata = prdata_q;
    assign pslverr = pready_q && access && !mapped;
    assign scl_out = 1'b0;
    assign sda_out = 1'b0;
    assign scl_oe = scl_oe_q;
    assign sda_oe = sda_oe_q;
    assign irq = irq_q;

    // one wait state, then answer
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_q <= 1'b0;
            prdata_q <= '0;
        end
        else
        begin
            pready_q <= access && !pready_q;
            if (access && !pready_q)
                prdata_q <= pwrite ? '0 : rd_mux;
        end
    end

    // software registers; only defined bits are stored
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            irq_en_q <= RST_IRQ_ENABLE;
            enable_q <= RST_TARGET_ENABLE;
        end
        else if (wr_fire)
        begin
            if (sel_mask)
                irq_en_q <= pwdata[BIT_DATA_IRQ];
            if (sel_ctrl)
                enable_q <= pwdata[BIT_TARGET_ENABLE];
        end
    end

    // shared byte: engine capture wins over a software write
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            data_q <= RST_DATA_BYTE;
        else if (rx_capture)
            data_q <= shift_q;
        else if (wr_fire && sel_data)
            data_q <= pwdata[DATA_MSB:0];
    end

    // raw data interrupt: set wins over clear
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            irq_raw_q <= 1'b0;
            irq_q <= 1'b0;
        end
        else
        begin
            if (data_event)
                irq_raw_q <= 1'b1;
            else if (wr_fire && sel_clear && pwdata[BIT_DATA_IRQ])
                irq_raw_q <= 1'b0;
            irq_q <= irq_masked;
        end
    end

    // pending flags: set wins over clear
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rx_pend_q <= 1'b0;
            tx_pend_q <= 1'b0;
        end
        else if (!enable_q)
        begin
            rx_pend_q <= 1'b0;
            tx_pend_q <= 1'b0;
        end
        else
        begin
            if (rx_capture)
                rx_pend_q <= 1'b1;
            else if (rd_fire && sel_data)
                rx_pend_q <= 1'b0;
            if (tx_request)
                tx_pend_q <= 1'b1;
            else if (tx_load)
                tx_pend_q <= 1'b0;
        end
    end

    // two flops on each line before use
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sync1_q <= '1;
            sync2_q <= '1;
            prev_q <= '1;
        end
        else
        begin
            sync1_q <= '{scl: scl_in, sda: sda_in};
            sync2_q <= sync1_q;
            prev_q <= sync2_q;
        end
    end

    // protocol engine
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_q <= ST_IDLE;
            shift_q <= '0;
            cnt_q <= '0;
            rw_q <= 1'b0;
            ack_ok_q <= 1'b0;
            scl_oe_q <= 1'b0;
            sda_oe_q <= 1'b0;
        end
        else if (!enable_q || stop_cond)
        begin
            state_q <= ST_IDLE;
            scl_oe_q <= 1'b0;
            sda_oe_q <= 1'b0;
        end
        else if (start_cond)
        begin
            state_q <= ST_ADDR;
            cnt_q <= '0;
            scl_oe_q <= 1'b0;
            sda_oe_q <= 1'b0;
        end
        else
        begin
            scl_oe_q <= stretch;
            unique case (state_q)
                ST_IDLE:
                    sda_oe_q <= 1'b0;
                ST_ADDR, ST_RX:
                begin
                    if (scl_rise)
                    begin
                        shift_q <= {shift_q[6:0], sync2_q.sda};
                        cnt_q <= cnt_q + 4'h1;
                    end
                    else if (scl_fall && byte_done)
                    begin
                        cnt_q <= '0;
                        if (state_q == ST_RX)
                        begin
                            sda_oe_q <= 1'b1;
                            state_q <= ST_RX_ACK;
                        end
                        else if (addr_hit)
                        begin
                            rw_q <= shift_q[0];
                            sda_oe_q <= 1'b1;
                            state_q <= ST_ADDR_ACK;
                        end
                        else
                            state_q <= ST_IDLE;
                    end
                end
                ST_ADDR_ACK:
                begin
                    if (scl_fall)
                    begin
                        sda_oe_q <= 1'b0;
                        cnt_q <= '0;
                        state_q <= rw_q ? ST_TX : ST_RX;
                    end
                end
                ST_RX_ACK:
                begin
                    if (scl_fall)
                    begin
                        sda_oe_q <= 1'b0;
                        state_q <= ST_RX;
                    end
                end
                ST_TX:
                begin
                    if (tx_load)
                    begin
                        shift_q <= pwdata[DATA_MSB:0];
                        sda_oe_q <= !pwdata[DATA_MSB];
                    end
                    else if (scl_fall && !tx_pend_q)
                    begin
                        if (cnt_q == BITS_PER_BYTE - 4'h1)
                        begin
                            sda_oe_q <= 1'b0;
                            state_q <= ST_TX_ACK;
                        end
                        else
                        begin
                            shift_q <= {shift_q[6:0], 1'b0};
                            sda_oe_q <= !shift_q[6];
                            cnt_q <= cnt_q + 4'h1;
                        end
                    end
                end
                ST_TX_ACK:
                begin
                    if (scl_rise)
                        ack_ok_q <= !sync2_q.sda;
                    else if (scl_fall)
                    begin
                        cnt_q <= '0;
                        state_q <= ack_ok_q ? ST_TX : ST_IDLE;
                    end
                end
            endcase
        end
    end

endmodule

// ### testbench/i2ct_target_properties.sv
/*
 * i2ct_target_properties: port-level checker for the target data/mask block.
 * Assumes the i2ct_pkg register map; bound to every i2ct_target instance.
 */
`timescale 1ns/1ns
module i2ct_target_properties
    import i2ct_pkg::*;
(
    input wire logic pclk, // system clock
    input wire logic presetn, // async reset, active low
    input wire logic psel, // apb select
    input wire logic penable, // apb access phase
    input wire logic pwrite, // apb direction
    input wire logic [APB_AW-1:0] paddr, // apb byte address
    input wire logic [APB_DW-1:0] pwdata, // apb write data
    input wire logic [APB_DW-1:0] prdata, // apb read data
    input wire logic pready, // apb ready
    input wire logic pslverr, // apb error
    input wire logic scl_oe, // clock stretch drive
    input wire logic irq // data interrupt
);
    logic mask_q;
    logic [3:0] since_q;
    wire done = psel && penable && pready;
    wire rd_done = done && !pwrite;
    wire mask_wr = done && pwrite && paddr == OFS_IRQ_MASK;
    wire rel_ok = done && (paddr == OFS_DATA_BYTE || (pwrite && paddr == OFS_CTRL_STATUS));
    wire mapped = paddr inside {OFS_CTRL_STATUS, OFS_DATA_BYTE, OFS_IRQ_MASK, OFS_IRQ_RAW,
        OFS_IRQ_MASKED, OFS_IRQ_CLEAR};

    // shadow of the mask bit as software last wrote it
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            mask_q <= RST_IRQ_ENABLE;
        else if (mask_wr)
            mask_q <= pwdata[BIT_DATA_IRQ];
    end

    // cycles since the last access that may free the clock
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            since_q <= 4'hF;
        else if (rel_ok)
            since_q <= 4'h0;
        else if (since_q != 4'hF)
            since_q <= since_q + 4'h1;
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_ready_pulse: assert property (pready |-> psel && penable ##1 !pready)
        else $error("pready outside a single access cycle");
    a_data_upper_zero: assert property (
        rd_done && paddr == OFS_DATA_BYTE |-> prdata[31:8] == 24'h000000)
        else $error("data register upper bits not zero");
    a_mask_readback: assert property (
        rd_done && paddr == OFS_IRQ_MASK |-> prdata == {31'h00000000, mask_q})
        else $error("mask register read back wrong");
    a_irq_blocked: assert property (!mask_q && !$past(mask_q) |-> !irq)
        else $error("interrupt raised while masked");
    a_irq_needs_mask: assert property ($rose(irq) |-> mask_q)
        else $error("interrupt rose without mask set");
    a_masked_gated: assert property (
        rd_done && paddr == OFS_IRQ_MASKED && !mask_q |-> prdata == 32'h00000000)
        else $error("masked status set while mask clear");
    a_stretch_release: assert property ($fell(scl_oe) |-> since_q < 4'h8)
        else $error("clock released without data access");
    a_unmapped_err: assert property (
        done && !mapped |-> pslverr && prdata == 32'h00000000)
        else $error("unmapped access not refused");

    c_irq: cover property ($rose(irq));
    c_release: cover property ($fell(scl_oe));
    c_refused: cover property (done && pslverr);
endmodule

bind i2ct_target i2ct_target_properties u_props (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .scl_oe(scl_oe), .irq(irq));

// ### testbench/i2ct_ctrl_model.sv
/*
 * i2ct_ctrl_model: behavioural bus controller for the target bench.
 * Assumes the bench resolves both lines as open drain with pull-ups.
 */
`timescale 1ns/1ns
module i2ct_ctrl_model (
    input wire logic scl_line, // resolved clock line
    input wire logic sda_line, // resolved data line
    output logic scl_pull, // pull clock low
    output logic sda_pull // pull data low
);
    initial
    begin
        scl_pull = 1'b0;
        sda_pull = 1'b0;
    end

    task automatic start();
        sda_pull = 1'b1;
        #80 scl_pull = 1'b1;
        #40;
    endtask

    // nine bits msb first; the last one is the ack slot
    task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
        for (int i = 8; i >= 0; i--)
        begin
            sda_pull = !tx[i];
            #40 scl_pull = 1'b0;
            wait (scl_line); // target may stretch
            #80 rx[i] = sda_line;
            scl_pull = 1'b1;
            #40;
        end
    endtask

    task automatic stop();
        sda_pull = 1'b1;
        #40 scl_pull = 1'b0;
        #80 sda_pull = 1'b0;
        #80;
    endtask
endmodule

// ### testbench/i2ct_target_tb_top.sv
/*
 * i2ct_target_tb_top: self-checking bench for the target data/mask block.
 * Assumes i2ct_pkg, the bound checker and the controller model.
 */
`timescale 1ns/1ns
`define CHK(nm, ex, got) begin total_checks++; if ((got) !== (ex)) begin fails++; \
    $display("ERROR %s exp %h got %h", nm, ex, got); end end
module i2ct_target_tb_top
    import i2ct_pkg::*;
;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [APB_AW-1:0] paddr = 8'h00;
    logic [APB_DW-1:0] pwdata = 32'h00000000;
    logic [APB_DW-1:0] prdata;
    logic [APB_DW-1:0] rv;
    logic pready, pslverr, errv, scl_oe, sda_oe, irq, scl_pull, sda_pull;
    logic scl_drv, sda_drv;
    wire scl_line = !(scl_oe || scl_pull);
    wire sda_line = !(sda_oe || sda_pull);
    int fails = 0;
    int total_checks = 0;

    initial
    begin
        forever #4 pclk = !pclk;
    end

    i2ct_target #(.OWN_ADDR(DEF_OWN_ADDR)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .scl_in(scl_line), .scl_out(scl_drv),
        .scl_oe(scl_oe), .sda_in(sda_line), .sda_out(sda_drv), .sda_oe(sda_oe), .irq(irq));
    i2ct_ctrl_model ctrl (.scl_line(scl_line), .sda_line(sda_line), .scl_pull(scl_pull),
        .sda_pull(sda_pull));

    task automatic end_of_test();
        if (fails == 0 && total_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
            @(posedge pclk);
        while (pready !== 1'b1 && n++ < 20);
        `CHK("pready", 1'b1, pready)
        rv = prdata;
        errv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic wait_status(input int b);
        int n;
        n = 0;
        do
            apb(1'b0, OFS_CTRL_STATUS, 32'h00000000);
        while (rv[b] !== 1'b1 && n++ < 400);
        `CHK("pending", 1'b1, rv[b])
    endtask

    task automatic t_regs();
        apb(1'b0, OFS_DATA_BYTE, 32'h00000000);
        `CHK("data reset", 32'h00000000, rv)
        apb(1'b0, OFS_IRQ_MASK, 32'h00000000);
        `CHK("mask reset", 32'h00000000, rv)
        apb(1'b0, 8'h20, 32'h00000000);
        `CHK("unmapped", 1'b1, errv)
        `CHK("drive lvl", 2'b00, {scl_drv, sda_drv})
        apb(1'b1, OFS_IRQ_MASK, 32'hFFFFFFFF);
        apb(1'b0, OFS_IRQ_MASK, 32'h00000000);
        `CHK("mask rsvd", 32'h00000001, rv)
        apb(1'b1, OFS_IRQ_MASK, rv & 32'hFFFFFFFE);
        apb(1'b0, OFS_IRQ_MASK, 32'h00000000);
        `CHK("mask clear", 32'h00000000, rv)
    endtask

    task automatic t_receive();
        logic [8:0] rx;
        apb(1'b1, OFS_CTRL_STATUS, 32'h00000001);
        fork
            begin
                ctrl.start();
                ctrl.xfer({DEF_OWN_ADDR, 2'b01}, rx);
                `CHK("addr ack", 1'b0, rx[0])
                ctrl.xfer({8'hA5, 1'b1}, rx);
                `CHK("data ack", 1'b0, rx[0])
                ctrl.stop();
            end
            begin
                wait_status(BIT_RECEIVE_PENDING);
                `CHK("stretch", 1'b1, scl_oe)
                apb(1'b0, OFS_IRQ_RAW, 32'h00000000);
                `CHK("raw rx", 32'h00000001, rv)
                apb(1'b0, OFS_IRQ_MASKED, 32'h00000000);
                `CHK("masked off", 32'h00000000, rv)
                `CHK("irq off", 1'b0, irq)
                apb(1'b1, OFS_IRQ_MASK, 32'h00000001);
                repeat (2) @(posedge pclk);
                `CHK("irq on", 1'b1, irq)
                apb(1'b0, OFS_IRQ_MASKED, 32'h00000000);
                `CHK("masked on", 32'h00000001, rv)
                `CHK("still held", 1'b0, scl_line)
                apb(1'b0, OFS_DATA_BYTE, 32'h00000000);
                `CHK("rx byte", 32'h000000A5, rv)
                apb(1'b1, OFS_IRQ_CLEAR, 32'h00000001);
                repeat (2) @(posedge pclk);
                `CHK("irq cleared", 1'b0, irq)
                apb(1'b1, OFS_IRQ_MASK, 32'h00000000);
            end
        join
    endtask

    task automatic t_transmit();
        logic [8:0] rx;
        fork
            begin
                ctrl.start();
                ctrl.xfer({DEF_OWN_ADDR, 2'b11}, rx);
                `CHK("rd addr ack", 1'b0, rx[0])
                ctrl.xfer(9'h1FF, rx);
                `CHK("tx byte", 8'h3C, rx[8:1])
                ctrl.stop();
            end
            begin
                wait_status(BIT_TRANSMIT_PENDING);
                apb(1'b0, OFS_IRQ_RAW, 32'h00000000);
                `CHK("raw tx", 32'h00000001, rv)
                `CHK("tx irq off", 1'b0, irq)
                apb(1'b1, OFS_DATA_BYTE, 32'hFFFFFF3C);
                apb(1'b0, OFS_DATA_BYTE, 32'h00000000);
                `CHK("tx data rd", 32'h0000003C, rv)
                apb(1'b1, OFS_IRQ_CLEAR, 32'h00000001);
            end
        join
    endtask

    initial
    begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_regs();
        t_receive();
        t_transmit();
        end_of_test();
    end

    initial
    begin
        #100000;
        fails++;
        end_of_test();
    end
endmodule
